// File: rtl/ccou_pkg.sv
// Function
// R1: block op: write base, then word count
// R2: word count reads zero once block done
// R3: global op: write one to global register
// R4: block and global ops, both cache levels
// R5: guard set against miss-inval-alloc-alloc corruption
// R6: writeback-only ops need no guard
// R7: software keeps memory idle, waits completion
// R8: mask interrupts, wait, sixteen nops, unmask
// R9: global register bit zero clears when done
// R10: fence stalls until coherence op completes
// R11: parallel flow: fence, freeze, poll, fence
// R12: word count decrements per processed line
package ccou_pkg;
   // register offsets on the link
   localparam logic [7:0] OFF_BASE = 8'h00;
   localparam logic [7:0] OFF_COUNT = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_L1_INV = 8'h0c;
   localparam logic [7:0] OFF_L1_FINV = 8'h10;
   localparam logic [7:0] OFF_L2_INV = 8'h14;
   localparam logic [7:0] OFF_L2_FINV = 8'h18;
   // field layout
   localparam int CNT_W = 16;
   localparam int CTRL_W = 3;
   localparam int CTRL_LEVEL_BIT = 2;
   localparam int SET_W = 8;
   localparam int SET_LSB = 6;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   // one line is 16 words, 64 bytes
   localparam logic [15:0] LINE_WORDS = 16'h0010;
   localparam logic [31:0] LINE_BYTES = 32'h00000040;
   localparam logic [7:0] LAST_SET = 8'hff;
   // quiet cycles after completion
   localparam logic [4:0] NOP_COUNT = 5'h10;
   // operation kinds and levels
   typedef enum logic [1:0] {
      KIND_WB = 2'b00,
      KIND_INV = 2'b01,
      KIND_FINV = 2'b10
   } ccou_kind_type;
   localparam logic LEVEL_L1 = 1'b0;
   localparam logic LEVEL_L2 = 1'b1;
   // device sequencer
   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00,
      DEV_BLOCK = 2'b01,
      DEV_GLOBAL = 2'b10
   } ccou_dev_state_type;
   // host sequencer
   typedef enum logic [3:0] {
      HST_IDLE = 4'b0000,
      HST_FENCE0 = 4'b0001,
      HST_WR_CTRL = 4'b0010,
      HST_WR_BASE = 4'b0011,
      HST_WR_CNT = 4'b0100,
      HST_WR_GLB = 4'b0101,
      HST_WAIT = 4'b0110,
      HST_POLL_RD = 4'b0111,
      HST_POLL_CHK = 4'b1000,
      HST_FENCE2 = 4'b1001,
      HST_NOPS = 4'b1010
   } ccou_host_state_type;
endpackage

// File: rtl/ccou_link_if.sv
// register port plus fence and freeze between core side and unit
interface ccou_link_if;
   logic [7:0] addr;       // register offset
   logic [31:0] wdata;     // write data
   logic wr;               // write strobe
   logic rd;               // read strobe
   logic [31:0] rdata;     // read data, cycle after rd
   logic fence_req;        // memory fence pending
   logic fence_stall;      // fence must keep waiting
   logic l1_freeze;        // level-one data cache frozen
   modport dev (input addr, wdata, wr, rd, fence_req, l1_freeze, output rdata, fence_stall);
   modport host (output addr, wdata, wr, rd, fence_req, l1_freeze, input rdata, fence_stall);
endinterface

// File: rtl/ccou_countdown.sv
// loadable down counter, stops at zero
module ccou_countdown #(
   parameter int W = 5
) (
   // clock and reset
   input logic clk_in,
   input logic rst_b_in,
   // control
   input logic load_in,
   input logic [W-1:0] value_in,
   // status
   output logic zero_out
);
   typedef struct packed {
      logic [W-1:0] cnt;  // remaining cycles
   } ccou_cnt_state_type;
   ccou_cnt_state_type q, d;

   // load wins over counting
   always_comb begin
      d = q;
      if (load_in) begin
         d.cnt = value_in;
      end else if (q.cnt != '0) begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign zero_out = (q.cnt == '0);
endmodule

// File: rtl/ccou_host.sv
// software side: issues coherence sequences over the link
module ccou_host import ccou_pkg::*; (
   // clock and reset
   input logic clk_in,
   input logic rst_b_in,
   // command from the core program
   input logic cmd_valid_in,
   input logic cmd_global_in,
   input logic cmd_level_in,
   input logic [1:0] cmd_kind_in,
   input logic [31:0] cmd_addr_in,
   input logic [15:0] cmd_count_in,
   input logic cmd_fence_in,
   input logic cmd_parallel_in,
   // status to the core program
   output logic cmd_ready_out,
   output logic done_out,
   output logic intr_disable_out,
   output logic traffic_hold_out,
   // link to the unit
   ccou_link_if.host link
);
   typedef struct packed {
      ccou_host_state_type st;
      logic glb;             // global command latched
      logic level;
      logic [1:0] kind;
      logic [31:0] base;
      logic [15:0] count;
      logic use_fence;
      logic par;             // parallel flow
      logic [7:0] poll_addr; // register that shows completion
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
      logic fence;
      logic freeze;
      logic hold;
      logic intr_dis;
      logic done;
   } ccou_host_reg_type;
   ccou_host_reg_type q, d;
   logic nop_load;  // start quiet period
   logic nop_zero;  // quiet period over
   logic [7:0] gaddr;

   // quiet period after completion
   ccou_countdown #(.W(5)) u_nops (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .load_in(nop_load),
      .value_in(NOP_COUNT),
      .zero_out(nop_zero)
   );

   // sequencer
   always_comb begin
      d = q;
      nop_load = 1'b0;
      // global register picked by level and kind; no global writeback here
      if (q.level == LEVEL_L1) begin
         gaddr = (q.kind == KIND_INV) ? OFF_L1_INV : OFF_L1_FINV;
      end else begin
         gaddr = (q.kind == KIND_INV) ? OFF_L2_INV : OFF_L2_FINV;
      end
      d.wr = 1'b0;
      d.rd = 1'b0;
      d.done = 1'b0;
      case (q.st)
         HST_IDLE: begin
            if (cmd_valid_in) begin
               d.glb = cmd_global_in;
               d.level = cmd_level_in;
               d.kind = cmd_kind_in;
               d.base = cmd_addr_in;
               d.count = cmd_count_in;
               d.use_fence = cmd_fence_in;
               d.par = cmd_parallel_in & ~cmd_global_in;
               d.intr_dis = 1'b1; // R8
               if (cmd_parallel_in && !cmd_global_in) begin
                  d.st = HST_FENCE0; // R11
               end else begin
                  d.hold = 1'b1; // R7
                  d.st = cmd_global_in ? HST_WR_GLB : HST_WR_CTRL;
               end
            end
         end
         // drain traffic, then freeze the cache
         HST_FENCE0: begin
            d.fence = 1'b1;
            if (q.fence && !link.fence_stall) begin
               d.fence = 1'b0;
               d.freeze = 1'b1; // R11
               d.st = HST_WR_CTRL;
            end
         end
         // kind and level go first, the unit latches them at launch
         HST_WR_CTRL: begin
            d.wr = 1'b1;
            d.addr = OFF_CTRL;
            d.wdata = {29'h0, q.level, q.kind};
            d.st = HST_WR_BASE;
         end
         // base strictly before count
         HST_WR_BASE: begin
            d.wr = 1'b1; // R1
            d.addr = OFF_BASE;
            d.wdata = q.base;
            d.st = HST_WR_CNT;
         end
         HST_WR_CNT: begin
            d.wr = 1'b1; // R1
            d.addr = OFF_COUNT;
            d.wdata = {16'h0, q.count};
            d.poll_addr = OFF_COUNT;
            d.st = q.par ? HST_POLL_RD : HST_WAIT;
         end
         // no base or count: a global walk covers every set
         HST_WR_GLB: begin
            d.wr = 1'b1; // R3
            d.addr = gaddr;
            d.wdata = 32'h00000001;
            d.poll_addr = gaddr;
            d.st = HST_WAIT;
         end
         // fence preferred, polling otherwise
         HST_WAIT: begin
            if (q.use_fence) begin
               d.fence = 1'b1;
               if (q.fence && !link.fence_stall) begin
                  d.fence = 1'b0; // R10
                  nop_load = 1'b1;
                  d.st = HST_NOPS;
               end
            end else begin
               d.st = HST_POLL_RD;
            end
         end
         HST_POLL_RD: begin
            d.rd = 1'b1;
            d.addr = q.poll_addr;
            d.st = HST_POLL_CHK;
         end
         // strobe still out on entry; the answer stands one cycle later only
         HST_POLL_CHK: begin
            if (q.rd) begin
               // strobe cycle carries no answer, so a zero here means nothing
               d.st = HST_POLL_CHK;
            end else if (q.glb ? (link.rdata[0] == 1'b0) : (link.rdata[15:0] == 16'h0)) begin // R9 R2
               if (q.par) begin
                  d.st = HST_FENCE2;
               end else begin
                  nop_load = 1'b1;
                  d.st = HST_NOPS;
               end
            end else begin
               d.st = HST_POLL_RD;
            end
         end
         HST_FENCE2: begin
            d.fence = 1'b1;
            if (q.fence && !link.fence_stall) begin
               d.fence = 1'b0;
               d.freeze = 1'b0; // R11
               nop_load = 1'b1;
               d.st = HST_NOPS;
            end
         end
         // quiet cycles, then release interrupts
         HST_NOPS: begin
            if (nop_zero) begin
               d.intr_dis = 1'b0; // R8
               d.hold = 1'b0;
               d.done = 1'b1;
               d.st = HST_IDLE;
            end
         end
         default: begin
            d.st = HST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs
   assign cmd_ready_out = (q.st == HST_IDLE);
   assign done_out = q.done;
   assign intr_disable_out = q.intr_dis;
   assign traffic_hold_out = q.hold;
   assign link.addr = q.addr;
   assign link.wdata = q.wdata;
   assign link.wr = q.wr;
   assign link.rd = q.rd;
   assign link.fence_req = q.fence;
   assign link.l1_freeze = q.freeze;
endmodule

// File: rtl/ccou_dev.sv
// coherence operation unit: block and global walks over both cache levels
module ccou_dev import ccou_pkg::*; (
   // clock and reset
   input logic clk_in,
   input logic rst_b_in,
   // core traffic towards the caches
   input logic core_req_in,
   input logic [7:0] core_set_in,
   output logic core_stall_out,
   // line operations towards the cache arrays
   output logic op_valid_out,
   output logic [31:0] op_addr_out,
   output logic [1:0] op_kind_out,
   output logic op_level_out,
   // busy indication
   output logic busy_out,
   // link from the core side
   ccou_link_if.dev link
);
   typedef struct packed {
      ccou_dev_state_type st;
      logic [31:0] base;     // next line address of a block op
      logic [15:0] count;    // words still to process
      logic [2:0] ctrl;      // block kind and level
      logic [3:0] glb;       // busy bit per global register
      logic [1:0] kind;      // running op kind
      logic level;           // running op level
      logic [7:0] set;       // next set of a global walk
      logic [7:0] last_set;  // set invalidated last cycle
      logic last_vld;        // last_set still hazardous
      logic [31:0] rdata;
      logic op_valid;
      logic [31:0] op_addr;
      logic [1:0] op_kind;
      logic op_level;
   } ccou_dev_reg_type;
   ccou_dev_reg_type q, d;

   logic busy;       // an operation is walking
   logic inv_op;     // running op drops lines
   logic [7:0] cur_set;
   logic guard_hit;  // core request hits the guarded set
   logic [1:0] gidx; // global register index on write

   // set currently under the walk
   assign busy = (q.st != DEV_IDLE);
   assign inv_op = (q.kind != KIND_WB); // R6
   assign cur_set = (q.st == DEV_BLOCK) ? q.base[SET_LSB +: SET_W] : q.set;

   // hold core allocations off the set being invalidated, and the one just
   // before, so miss, invalidate and two allocations never line up there;
   // a frozen level-one cache does not allocate, so its own ops skip this
   always_comb begin
      guard_hit = 1'b0;
      if (core_req_in && inv_op && !(link.l1_freeze && q.level == LEVEL_L1)) begin
         if (busy && core_set_in == cur_set) begin
            guard_hit = 1'b1; // R5
         end
         if (q.last_vld && core_set_in == q.last_set) begin
            guard_hit = 1'b1; // R5
         end
      end
   end

   // decode which global register a write addresses
   always_comb begin
      case (link.addr)
         OFF_L1_INV: gidx = 2'b00;
         OFF_L1_FINV: gidx = 2'b01;
         OFF_L2_INV: gidx = 2'b10;
         OFF_L2_FINV: gidx = 2'b11;
         default: gidx = 2'b00;
      endcase
   end

   // register port, start logic and walk
   always_comb begin
      d = q;
      d.op_valid = 1'b0;
      d.rdata = 32'h0;
      d.last_vld = 1'b0;
      // read data stands for one cycle only
      if (link.rd) begin
         case (link.addr)
            OFF_BASE: d.rdata = q.base;
            OFF_COUNT: d.rdata = {16'h0, q.count}; // R2
            OFF_CTRL: d.rdata = {29'h0, q.ctrl};
            OFF_L1_INV: d.rdata = {31'h0, q.glb[0]}; // R9
            OFF_L1_FINV: d.rdata = {31'h0, q.glb[1]}; // R9
            OFF_L2_INV: d.rdata = {31'h0, q.glb[2]}; // R9
            OFF_L2_FINV: d.rdata = {31'h0, q.glb[3]}; // R9
            default: d.rdata = 32'h0;
         endcase
      end
      case (q.st)
         // writes only take effect while idle; a running walk is never
         // retargeted, so software must wait for completion first
         DEV_IDLE: begin
            if (link.wr) begin
               case (link.addr)
                  OFF_BASE: begin
                     d.base = link.wdata; // R1
                  end
                  OFF_CTRL: begin
                     d.ctrl = link.wdata[CTRL_W-1:0];
                  end
                  OFF_COUNT: begin
                     // count write launches the block op
                     if (link.wdata[CNT_W-1:0] != 16'h0) begin
                        d.count = link.wdata[CNT_W-1:0]; // R1
                        d.kind = q.ctrl[1:0];
                        d.level = q.ctrl[CTRL_LEVEL_BIT]; // R4
                        d.st = DEV_BLOCK;
                     end
                  end
                  OFF_L1_INV, OFF_L1_FINV, OFF_L2_INV, OFF_L2_FINV: begin
                     // writing one launches the global op
                     if (link.wdata[0]) begin
                        d.glb[gidx] = 1'b1; // R3
                        d.kind = gidx[0] ? KIND_FINV : KIND_INV;
                        d.level = gidx[1] ? LEVEL_L2 : LEVEL_L1; // R4
                        d.set = 8'h00;
                        d.st = DEV_GLOBAL;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         // one line per cycle; stalled core requests do not slow the walk
         DEV_BLOCK: begin
            d.op_valid = 1'b1;
            d.op_addr = q.base;
            d.op_kind = q.kind;
            d.op_level = q.level;
            d.last_set = q.base[SET_LSB +: SET_W];
            d.last_vld = inv_op;
            d.base = q.base + LINE_BYTES;
            if (q.count > LINE_WORDS) begin
               d.count = q.count - LINE_WORDS; // R12
            end else begin
               d.count = 16'h0; // R2
               d.st = DEV_IDLE;
            end
         end
         // every set of the chosen level, set index in the address
         DEV_GLOBAL: begin
            d.op_valid = 1'b1;
            d.op_addr = {18'h0, q.set, 6'h00};
            d.op_kind = q.kind;
            d.op_level = q.level;
            d.last_set = q.set;
            d.last_vld = 1'b1;
            d.set = q.set + 8'h01;
            if (q.set == LAST_SET) begin
               d.glb = 4'h0; // R9
               d.st = DEV_IDLE;
            end
         end
         default: begin
            d.st = DEV_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= '0;
         q.ctrl <= CTRL_RESET;
      end else begin
         q <= d;
      end
   end

   // fence waits while a walk runs
   assign link.fence_stall = link.fence_req & busy; // R10
   assign link.rdata = q.rdata;
   assign core_stall_out = guard_hit; // R5
   assign op_valid_out = q.op_valid;
   assign op_addr_out = q.op_addr;
   assign op_kind_out = q.op_kind;
   assign op_level_out = q.op_level;
   assign busy_out = busy;
endmodule

// File: sim/ccou_asserts.sv
// link watcher: relations between the two ends on the register port
module ccou_asserts import ccou_pkg::*; (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // fence and freeze
   input wire logic fence_req,
   input wire logic fence_stall,
   input wire logic l1_freeze
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // count write that really launches a block walk
   wire logic cnt_go = wr && addr == OFF_COUNT && wdata[15:0] != 16'h0000;
   // write to one of the four global registers
   wire logic glb_sel = wr && addr >= OFF_L1_INV && addr <= OFF_L2_FINV;
   wire logic glb_go = glb_sel && wdata[0];
   AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h00000000)
      else $error("read data seen outside its answer cycle");
   AST_STROBE_EXCL: assert property (!(wr && rd))
      else $error("write and read strobes together");
   AST_STALL_REQ: assert property (fence_stall |-> fence_req)
      else $error("fence stall without a fence");
   AST_BASE_FIRST: assert property (wr && addr == OFF_COUNT |-> $past(wr) && $past(addr) == OFF_BASE)
      else $error("count written without base just before");
   AST_BLOCK_FENCE: assert property ($past(cnt_go) && fence_req |-> fence_stall)
      else $error("fence not held after block launch");
   AST_GLOBAL_FENCE: assert property ($past(glb_go) && fence_req |-> fence_stall)
      else $error("fence not held after global launch");
   AST_GLOBAL_ONE: assert property (glb_sel |-> wdata[0])
      else $error("global register written without bit zero");
   AST_POLL_GAP: assert property (rd |=> !rd)
      else $error("poll reads back to back");
   AST_FREEZE_FENCED: assert property ($changed(l1_freeze) |-> !fence_stall)
      else $error("freeze changed while fence stalled");
   // main scenarios reached
   AST_COV_BLOCK: cover property (cnt_go);
   AST_COV_GLOBAL: cover property (glb_go);
   AST_COV_FREEZE: cover property ($rose(l1_freeze));
endmodule

// File: sim/tb_cache_coherence_operation_unit.sv
// both ends joined on the link; commands in, line operations watched
module tb_cache_coherence_operation_unit import ccou_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in, rst_b_in;
   // core program command
   logic cmd_valid_in, cmd_global_in, cmd_level_in, cmd_fence_in, cmd_parallel_in;
   logic [1:0] cmd_kind_in;
   logic [31:0] cmd_addr_in;
   logic [15:0] cmd_count_in;
   logic cmd_ready_out, done_out, intr_disable_out, traffic_hold_out;
   // core traffic and cache side
   logic core_req_in, core_stall_out, op_valid_out, op_level_out, busy_out;
   logic [7:0] core_set_in;
   logic [31:0] op_addr_out;
   logic [1:0] op_kind_out;
   // bookkeeping
   int n_fail, cmp_count, n_pulse, last_pulse, cyc;
   logic [31:0] exp_addr;
   logic guard_on;
   ccou_link_if i_ccou_link_if();
   ccou_host i_ccou_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
      .cmd_global_in(cmd_global_in), .cmd_level_in(cmd_level_in), .cmd_kind_in(cmd_kind_in),
      .cmd_addr_in(cmd_addr_in), .cmd_count_in(cmd_count_in), .cmd_fence_in(cmd_fence_in),
      .cmd_parallel_in(cmd_parallel_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
      .intr_disable_out(intr_disable_out), .traffic_hold_out(traffic_hold_out), .link(i_ccou_link_if));
   ccou_dev i_ccou_dev (.clk_in(clk_in), .rst_b_in(rst_b_in), .core_req_in(core_req_in),
      .core_set_in(core_set_in), .core_stall_out(core_stall_out), .op_valid_out(op_valid_out),
      .op_addr_out(op_addr_out), .op_kind_out(op_kind_out), .op_level_out(op_level_out),
      .busy_out(busy_out), .link(i_ccou_link_if));
   ccou_asserts i_ccou_asserts (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr(i_ccou_link_if.addr),
      .wdata(i_ccou_link_if.wdata), .wr(i_ccou_link_if.wr), .rd(i_ccou_link_if.rd),
      .rdata(i_ccou_link_if.rdata), .fence_req(i_ccou_link_if.fence_req),
      .fence_stall(i_ccou_link_if.fence_stall), .l1_freeze(i_ccou_link_if.l1_freeze));
   // one comparison, counted
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // global writeback goes out as flush-invalidate
   function automatic logic [1:0] exp_kind(input logic g, input logic [1:0] k);
      return (g && k == KIND_WB) ? KIND_FINV : k;
   endfunction
   // one line per 16 words, rounded up; global walks every set
   function automatic int exp_pulses(input logic g, input logic [15:0] n);
      return g ? 256 : (int'(n) + 15) / 16;
   endfunction
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // core traffic, kept off while the host asks for an idle memory;
   // half the time aimed at the set about to be walked
   always @(posedge clk_in) begin
      core_req_in <= (traffic_hold_out === 1'b1) ? 1'b0 : 1'($urandom);
      core_set_in <= ($urandom % 2) ? exp_addr[13:6] : 8'($urandom);
   end
   // line operation monitor, sampled mid cycle
   always @(negedge clk_in) begin
      cyc++;
      if (op_valid_out === 1'b1) begin
         check("op_addr", op_addr_out, exp_addr);
         check("op_kind", 32'(op_kind_out), 32'(exp_kind(cmd_global_in, cmd_kind_in)));
         check("op_level", 32'(op_level_out), 32'(cmd_level_in));
         // freeze lifts the guard for level-one walks
         if (!(guard_on && !(i_ccou_link_if.l1_freeze === 1'b1 && cmd_level_in == LEVEL_L1))) begin
            check("stall_off", 32'(core_stall_out), 32'h0);
         end else if (core_req_in && core_set_in == exp_addr[13:6]) begin
            check("stall_on", 32'(core_stall_out), 32'h1);
         end
         exp_addr = exp_addr + LINE_BYTES;
         n_pulse++;
         last_pulse = cyc;
      end
   end
   // one command through the host, then compare the whole walk
   task automatic run(input logic g, lvl, input logic [1:0] k, input logic [15:0] n, input logic f, p);
      logic [31:0] a;
      int t;
      a = $urandom;
      exp_addr = g ? 32'h00000000 : {a[31:6], 6'h00};
      guard_on = (exp_kind(g, k) != KIND_WB);
      n_pulse = 0;
      @(posedge clk_in);
      cmd_valid_in <= 1'b1;
      cmd_global_in <= g;
      cmd_level_in <= lvl;
      cmd_kind_in <= k;
      cmd_addr_in <= {a[31:6], 6'h00};
      cmd_count_in <= n;
      cmd_fence_in <= f;
      cmd_parallel_in <= p;
      @(posedge clk_in);
      cmd_valid_in <= 1'b0;
      @(posedge clk_in);
      @(negedge clk_in);
      check("intr_disable", 32'(intr_disable_out), 32'h1);
      check("traffic_hold", 32'(traffic_hold_out), 32'(!p));
      t = 0;
      while (done_out !== 1'b1 && t < 3000) begin
         @(negedge clk_in);
         t++;
      end
      check("done_in_time", 32'(t < 3000), 32'h1);
      check("pulses", n_pulse, exp_pulses(g, n));
      check("busy_idle", 32'(busy_out), 32'h0);
      check("quiet_gap", 32'(cyc - last_pulse >= 16), 32'h1);
      @(negedge clk_in);
      check("intr_restored", 32'(intr_disable_out), 32'h0);
      check("ready", 32'(cmd_ready_out), 32'h1);
      $display("test done: global %0d level %0d kind %0d count %0d", g, lvl, k, n);
   endtask
   // watchdog, far beyond the expected few thousand cycles
   initial begin
      #(60000 * 100);
      n_fail++;
      stop_test();
   end
   initial begin
      rst_b_in = 1'b0;
      {cmd_valid_in, cmd_global_in, cmd_level_in, cmd_fence_in, cmd_parallel_in} = 5'h00;
      cmd_kind_in = 2'h0;
      cmd_addr_in = 32'h00000000;
      cmd_count_in = 16'h0000;
      core_req_in = 1'b0;
      core_set_in = 8'h00;
      exp_addr = 32'h00000000;
      guard_on = 1'b0;
      {n_fail, cmp_count, n_pulse, last_pulse, cyc} = '0;
      void'($urandom(32'hf8ecee5b));
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      // every level and kind, block one word past a line boundary then global
      for (int i = 0; i < 6; i++) begin
         run(1'b0, 1'(i / 3), 2'(i % 3), (i % 2) ? 16'h0011 : 16'(16 * (i % 3) + 1), 1'(i), 1'b0);
         run(1'b1, 1'(i / 3), 2'(i % 3), 16'h0000, 1'(i + 1), 1'b0);
      end
      // parallel flow: frozen level one, then level two, guarded for invalidate and unguarded for writeback
      run(1'b0, LEVEL_L1, KIND_FINV, 16'h0040, 1'b0, 1'b1);
      run(1'b0, LEVEL_L1, KIND_INV, 16'h0100, 1'b0, 1'b1);
      run(1'b0, LEVEL_L2, KIND_INV, 16'h0100, 1'b0, 1'b1);
      run(1'b0, LEVEL_L2, KIND_WB, 16'h0040, 1'b0, 1'b1);
      // random block operations
      repeat (8) begin
         run(1'b0, 1'($urandom), 2'($urandom % 3), 16'(1 + $urandom % 512), 1'($urandom), 1'($urandom));
      end
      stop_test();
   end
endmodule
